// ### rtl/low_voltage_power_mode_control.sv
// Purpose: low-voltage detect/warning flags and stop mode selection
// Assumes: comparator outputs are asynchronous; stop and reset-kind inputs are on mclk
// Notes: registers reached over classic wishbone, one byte per word
//
// Overview of operation
// - detect flag bit7, set only when enabled
// - writing one at bit6 clears detect flag
// - interrupt while flag and enable bit5
// - reset when flag, bit4 and enable
// - bit3 keeps detection running in stop
// - bit2 enables detect logic and qualifies reset and stop keep
// - bit0 drives reference buffer enable
// - warning flag set below trip, sticky
// - warning ack clears only without warning
// - bit5 selects detect trip point
// - bit4 selects warning trip point
// - stop exit flag set on recovery while bit0 set
// - writing one at bit2 clears exit flag
// - bit0 write once, selects stop depth
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "lvpm_defines.svh"
module low_voltage_power_mode_control (
    input wire logic mclk,
    input wire logic srst,
    input wire logic power_on_reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic supply_detect,
    input wire logic supply_warning,
    input wire logic stop_active,
    input wire logic stop_recovered,
    output logic detect_comparator_on,
    output logic detect_trip_select,
    output logic warning_trip_select,
    output logic reference_buffer_enable,
    output logic stop_depth_select,
    output logic detect_irq,
    output logic detect_reset_req,
    output logic irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    lvpm_pkg::state_t st_r;
    lvpm_pkg::state_t st_nxt;
    logic any_rst;
    logic access;
    logic wr_lo;
    logic [7:0] wd;
    logic [7:0] rd;
    logic det_run;

    assign any_rst = srst | power_on_reset;
    assign access = wb_cyc_i & wb_stb_i;
    // write commits at the edge that sees ack high
    assign wr_lo = access & wb_we_i & st_r.ack & wb_sel_i[0];
    assign wd = wb_dat_i[7:0];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        rd = 8'h00;
        // second flop only reads the first
        st_nxt.det_s1 = supply_detect;
        st_nxt.det_s2 = st_r.det_s1;
        st_nxt.warn_s1 = supply_warning;
        st_nxt.warn_s2 = st_r.warn_s1;

        // detection off in stop unless kept
        det_run = st_r.detect_enable & (~stop_active | st_r.detect_stop_enable);

        // register writes, first byte lane only
        if (wr_lo && wb_adr_i == `LVPM_ADR_DETECT)
        begin
            if (wd[`LVPM_DACK_BIT])
                st_nxt.detect_flag = 1'h0;
            st_nxt.detect_interrupt_enable = wd[`LVPM_DIE_BIT];
            st_nxt.detect_reset_enable = wd[`LVPM_DRE_BIT];
            st_nxt.detect_stop_enable = wd[`LVPM_DSE_BIT];
            st_nxt.detect_enable = wd[`LVPM_DE_BIT];
            // reserved bit not stored, reads zero
            st_nxt.reference_buffer_enable = wd[`LVPM_RBE_BIT];
        end
        if (wr_lo && wb_adr_i == `LVPM_ADR_WARN)
        begin
            // clear only without a present warning
            if (wd[`LVPM_WACK_BIT] && !st_r.warn_s2)
                st_nxt.warning_flag = 1'h0;
            st_nxt.detect_trip_select = wd[`LVPM_DTS_BIT];
            st_nxt.warning_trip_select = wd[`LVPM_WTS_BIT];
            if (wd[`LVPM_SACK_BIT])
                st_nxt.stop_exit_flag = 1'h0;
            if (!st_r.depth_written)
            begin
                st_nxt.stop_depth_select = wd[`LVPM_SDS_BIT];
                st_nxt.depth_written = 1'h1;
            end
        end
        if (wr_lo && wb_adr_i == `LVPM_ADR_EVT)
            st_nxt.evt = st_r.evt & ~wd[`LVPM_EV_W-1:0];
        if (wr_lo && wb_adr_i == `LVPM_ADR_MASK)
            st_nxt.mask = wd[`LVPM_EV_W-1:0];

        // hardware sets win over software clears
        // set only while detection operates
        if (det_run && st_r.det_s2)
        begin
            st_nxt.detect_flag = 1'h1;
            st_nxt.evt[`LVPM_EV_DETECT] = 1'h1;
        end
        if (st_r.warn_s2)
        begin
            st_nxt.warning_flag = 1'h1;
            st_nxt.evt[`LVPM_EV_WARN] = 1'h1;
        end
        if (stop_recovered && st_r.stop_depth_select)
        begin
            st_nxt.stop_exit_flag = 1'h1;
            st_nxt.evt[`LVPM_EV_EXIT] = 1'h1;
        end

        // read mux; acknowledge bits read zero
        unique case (wb_adr_i)
            `LVPM_ADR_DETECT:
            begin
                rd[`LVPM_DF_BIT] = st_r.detect_flag;
                rd[`LVPM_DIE_BIT] = st_r.detect_interrupt_enable;
                rd[`LVPM_DRE_BIT] = st_r.detect_reset_enable;
                rd[`LVPM_DSE_BIT] = st_r.detect_stop_enable;
                rd[`LVPM_DE_BIT] = st_r.detect_enable;
                rd[`LVPM_RBE_BIT] = st_r.reference_buffer_enable;
            end
            `LVPM_ADR_WARN:
            begin
                rd[`LVPM_WF_BIT] = st_r.warning_flag;
                rd[`LVPM_DTS_BIT] = st_r.detect_trip_select;
                rd[`LVPM_WTS_BIT] = st_r.warning_trip_select;
                rd[`LVPM_SEF_BIT] = st_r.stop_exit_flag;
                rd[`LVPM_SDS_BIT] = st_r.stop_depth_select;
            end
            `LVPM_ADR_EVT:
                rd[`LVPM_EV_W-1:0] = st_r.evt;
            `LVPM_ADR_MASK:
                rd[`LVPM_EV_W-1:0] = st_r.mask;
            default:
                rd = 8'h00;
        endcase

        // one-wait-state slave, unmapped reads zero
        st_nxt.ack = access & ~st_r.ack;
        st_nxt.dat = (access & ~st_r.ack) ? {24'h000000, rd} : `LVPM_RST_DAT;

        // interrupt request while flag and enable
        st_nxt.det_irq = st_nxt.detect_flag & st_nxt.detect_interrupt_enable;
        // enable qualifies flag, reset and stop
        st_nxt.rst_req = st_nxt.detect_flag & st_nxt.detect_reset_enable
                         & st_nxt.detect_enable;
        st_nxt.comp_on = st_nxt.detect_enable
                         & (~stop_active | st_nxt.detect_stop_enable);
        st_nxt.irq = |(st_nxt.evt & st_nxt.mask);

        if (any_rst)
        begin
            st_nxt.detect_flag = `LVPM_RST_BIT;
            st_nxt.detect_interrupt_enable = `LVPM_RST_BIT;
            st_nxt.detect_reset_enable = `LVPM_RST_BIT;
            st_nxt.detect_stop_enable = `LVPM_RST_BIT;
            st_nxt.detect_enable = `LVPM_RST_BIT;
            st_nxt.reference_buffer_enable = `LVPM_RST_BIT;
            st_nxt.warning_flag = `LVPM_RST_BIT;
            st_nxt.stop_exit_flag = `LVPM_RST_BIT;
            st_nxt.stop_depth_select = `LVPM_RST_BIT;
            st_nxt.depth_written = `LVPM_RST_BIT;
            st_nxt.evt = `LVPM_RST_EV;
            st_nxt.mask = `LVPM_RST_EV;
            st_nxt.ack = `LVPM_RST_BIT;
            st_nxt.dat = `LVPM_RST_DAT;
            st_nxt.irq = `LVPM_RST_BIT;
            st_nxt.det_irq = `LVPM_RST_BIT;
            st_nxt.rst_req = `LVPM_RST_BIT;
            st_nxt.comp_on = `LVPM_RST_BIT;
            // trip selects cleared by power-on only
            if (power_on_reset)
            begin
                st_nxt.detect_trip_select = `LVPM_RST_BIT;
                st_nxt.warning_trip_select = `LVPM_RST_BIT;
            end
        end
    end

    // trip selects start unknown until the first power-on reset
    always_ff @(posedge mclk)
    begin
        st_r <= st_nxt;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign detect_comparator_on = st_r.comp_on;
    assign detect_trip_select = st_r.detect_trip_select;
    assign warning_trip_select = st_r.warning_trip_select;
    assign reference_buffer_enable = st_r.reference_buffer_enable;
    assign stop_depth_select = st_r.stop_depth_select;
    assign detect_irq = st_r.det_irq;
    assign detect_reset_req = st_r.rst_req;
    assign irq = st_r.irq;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (any_rst);

    // write strobes per register, as the next-state logic sees them
    logic wr_det;
    logic wr_warn;
    assign wr_det = wr_lo && (wb_adr_i == `LVPM_ADR_DETECT);
    assign wr_warn = wr_lo && (wb_adr_i == `LVPM_ADR_WARN);

    // ---------------------------------------------------------------
    // detect register
    // ---------------------------------------------------------------
    AST_DETECT_SET: assert property (
        (det_run && st_r.det_s2) |=> st_r.detect_flag)
        else $error("detect flag not set on event");
    AST_DETECT_QUAL: assert property (
        (!st_r.detect_flag && !st_r.detect_enable) |=> !st_r.detect_flag)
        else $error("detect flag set while disabled");
    AST_DETECT_ACK: assert property (
        (wr_lo && wb_adr_i == `LVPM_ADR_DETECT && wd[`LVPM_DACK_BIT]
         && !(det_run && st_r.det_s2)) |=> !st_r.detect_flag)
        else $error("detect acknowledge did not clear");
    AST_DET_IRQ: assert property (
        detect_irq == (st_r.detect_flag && st_r.detect_interrupt_enable))
        else $error("detect interrupt mismatch");
    AST_RST_REQ: assert property (
        detect_reset_req |-> (st_r.detect_flag && st_r.detect_reset_enable
                              && st_r.detect_enable))
        else $error("reset request without cause");
    AST_STOP_OFF: assert property (
        (stop_active && !st_r.detect_stop_enable) |=> !detect_comparator_on
        || !$stable(stop_active) || $changed(st_r.detect_stop_enable))
        else $error("detection kept in stop");
    AST_DETECT_HOLD: assert property (
        (st_r.detect_flag && !(wr_det && wd[`LVPM_DACK_BIT])) |=> st_r.detect_flag)
        else $error("detect flag cleared without acknowledge");
    AST_DET_IRQ_SET: assert property (
        (st_r.detect_flag && st_r.detect_interrupt_enable && !wr_det) |=> detect_irq)
        else $error("detect interrupt not requested");
    AST_RST_REQ_SET: assert property (
        (st_r.detect_flag && st_r.detect_reset_enable && st_r.detect_enable && !wr_det)
        |=> detect_reset_req)
        else $error("reset request missing");
    AST_STOP_KEEP: assert property (
        (st_r.detect_enable && st_r.detect_stop_enable && !wr_det) |=> detect_comparator_on)
        else $error("detection dropped although kept in stop");
    AST_CMP_OFF: assert property (
        (!st_r.detect_enable && !wr_det) |=> !detect_comparator_on)
        else $error("comparator on while detection disabled");
    AST_RBE_ON: assert property (
        (wr_det && wd[`LVPM_RBE_BIT]) |=> reference_buffer_enable)
        else $error("reference buffer not enabled");
    AST_RBE_OFF: assert property (
        (wr_det && !wd[`LVPM_RBE_BIT]) |=> !reference_buffer_enable)
        else $error("reference buffer not disabled");
    AST_DETECT_READ: assert property (
        (wb_ack_o && wb_adr_i == `LVPM_ADR_DETECT)
        |-> (!wb_dat_o[`LVPM_DACK_BIT] && !wb_dat_o[1]))
        else $error("detect acknowledge or reserved bit read as one");

    // ---------------------------------------------------------------
    // warning and stop register
    // ---------------------------------------------------------------
    AST_WARN_STICKY: assert property (
        (st_r.warning_flag && st_r.warn_s2) |=> st_r.warning_flag)
        else $error("warning flag cleared while warning present");
    AST_WARN_SET: assert property (
        st_r.warn_s1 ##1 st_r.warn_s2 |=> st_r.warning_flag)
        else $error("warning flag not set");
    AST_DEPTH_ONCE: assert property (
        st_r.depth_written |=> $stable(st_r.stop_depth_select))
        else $error("stop depth changed after first write");
    AST_EXIT_SET: assert property (
        (stop_recovered && st_r.stop_depth_select) |=> st_r.stop_exit_flag)
        else $error("stop exit flag not set");
    AST_WARN_ACK: assert property (
        (wr_warn && wd[`LVPM_WACK_BIT] && !st_r.warn_s2) |=> !st_r.warning_flag)
        else $error("warning acknowledge did not clear");
    AST_DTS_HIGH: assert property (
        (wr_warn && wd[`LVPM_DTS_BIT]) |=> detect_trip_select)
        else $error("high detect trip point not selected");
    AST_DTS_LOW: assert property (
        (wr_warn && !wd[`LVPM_DTS_BIT]) |=> !detect_trip_select)
        else $error("low detect trip point not selected");
    AST_WTS_HIGH: assert property (
        (wr_warn && wd[`LVPM_WTS_BIT]) |=> warning_trip_select)
        else $error("high warning trip point not selected");
    AST_WTS_LOW: assert property (
        (wr_warn && !wd[`LVPM_WTS_BIT]) |=> !warning_trip_select)
        else $error("low warning trip point not selected");
    AST_EXIT_ONLY: assert property (
        (!st_r.stop_exit_flag && !(stop_recovered && st_r.stop_depth_select))
        |=> !st_r.stop_exit_flag)
        else $error("stop exit flag set without recovery");
    AST_EXIT_ACK: assert property (
        (wr_warn && wd[`LVPM_SACK_BIT] && !(stop_recovered && st_r.stop_depth_select))
        |=> !st_r.stop_exit_flag)
        else $error("stop exit acknowledge did not clear");
    AST_DEPTH_FIRST: assert property (
        (wr_warn && !st_r.depth_written && wd[`LVPM_SDS_BIT]) |=> stop_depth_select)
        else $error("first stop depth write lost");
    AST_WARN_READ: assert property (
        (wb_ack_o && wb_adr_i == `LVPM_ADR_WARN)
        |-> (!wb_dat_o[`LVPM_WACK_BIT] && !wb_dat_o[`LVPM_SACK_BIT]))
        else $error("warning register acknowledge bit read as one");

    // ---------------------------------------------------------------
    // bus, reset and events
    // ---------------------------------------------------------------
    AST_ACK_ONE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (
        !wb_ack_o |-> (wb_dat_o == 32'h00000000))
        else $error("read data outside acknowledge");
    AST_IRQ_HOLD: assert property (
        (|(st_r.evt & st_r.mask) && !wr_lo) |=> irq)
        else $error("interrupt dropped while unmasked event pending");
    // reset checks watch the reset itself, so they override the default disable
    AST_TRIP_KEEP: assert property (@(posedge mclk) disable iff (1'b0)
        (srst && !power_on_reset && !wr_warn)
        |=> ($stable(detect_trip_select) && $stable(warning_trip_select)))
        else $error("trip select lost on a non power-on reset");
    AST_POR_CLEAR: assert property (@(posedge mclk) disable iff (1'b0)
        power_on_reset |=> (!detect_trip_select && !warning_trip_select))
        else $error("trip select kept through power-on reset");
    AST_RST_CLEAR: assert property (@(posedge mclk) disable iff (1'b0)
        any_rst |=> (!st_r.detect_flag && !st_r.warning_flag && !st_r.stop_exit_flag
                     && !st_r.stop_depth_select && !irq && !detect_reset_req && !wb_ack_o))
        else $error("register not cleared by reset");

    COV_DETECT_RESET: cover property (detect_reset_req);
    COV_WARN_ACK_HELD: cover property (
        wr_lo && wb_adr_i == `LVPM_ADR_WARN && wd[`LVPM_WACK_BIT] && st_r.warn_s2);
    COV_EXIT: cover property (st_r.stop_exit_flag ##[1:20] !st_r.stop_exit_flag);
    COV_IRQ: cover property (irq);
    COV_DEPTH_LOCK: cover property (wr_warn && st_r.depth_written);

endmodule : low_voltage_power_mode_control
`default_nettype wire

// ### rtl/lvpm_defines.svh
// Purpose: offsets, field positions and reset values of the power mode control block
// Assumes: 32-bit classic wishbone, word aligned registers
// Notes: definitions only
`ifndef LVPM_DEFINES_SVH
`define LVPM_DEFINES_SVH
`define LVPM_ADR_DETECT 4'h0
`define LVPM_ADR_WARN 4'h4
`define LVPM_ADR_EVT 4'h8
`define LVPM_ADR_MASK 4'hc
`define LVPM_DF_BIT 7
`define LVPM_DACK_BIT 6
`define LVPM_DIE_BIT 5
`define LVPM_DRE_BIT 4
`define LVPM_DSE_BIT 3
`define LVPM_DE_BIT 2
`define LVPM_RBE_BIT 0
`define LVPM_WF_BIT 7
`define LVPM_WACK_BIT 6
`define LVPM_DTS_BIT 5
`define LVPM_WTS_BIT 4
`define LVPM_SEF_BIT 3
`define LVPM_SACK_BIT 2
`define LVPM_SDS_BIT 0
`define LVPM_EV_DETECT 0
`define LVPM_EV_WARN 1
`define LVPM_EV_EXIT 2
`define LVPM_EV_W 3
`define LVPM_RST_BIT 1'h0
`define LVPM_RST_EV 3'h0
`define LVPM_RST_DAT 32'h0
`endif

// ### rtl/lvpm_pkg.sv
// Purpose: types of the power mode control block
// Assumes: lvpm_defines.svh
// Notes: one packed state record
`include "lvpm_defines.svh"
package lvpm_pkg;
    typedef struct packed {
        logic det_s1;
        logic det_s2;
        logic warn_s1;
        logic warn_s2;
        logic detect_flag;
        logic detect_interrupt_enable;
        logic detect_reset_enable;
        logic detect_stop_enable;
        logic detect_enable;
        logic reference_buffer_enable;
        logic warning_flag;
        logic detect_trip_select;
        logic warning_trip_select;
        logic stop_exit_flag;
        logic stop_depth_select;
        logic depth_written;
        logic [`LVPM_EV_W-1:0] evt;
        logic [`LVPM_EV_W-1:0] mask;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic det_irq;
        logic rst_req;
        logic comp_on;
    } state_t;
endpackage : lvpm_pkg

// ### tb/supply_model.sv
// Purpose: behavioural supply comparators facing the power mode block
// Assumes: sag 0 nominal, 1 between trip points, 2 below both
// Notes: detect output silent while its comparator is switched off
`timescale 1ns/100ps
`default_nettype none
module supply_model (
    input wire logic [1:0] sag,
    input wire logic detect_comparator_on,
    input wire logic detect_trip_select,
    input wire logic warning_trip_select,
    output logic supply_detect,
    output logic supply_warning
);
    // ----------------------------------------
    // comparators
    // ----------------------------------------
    // high trip sooner
    assign supply_detect = detect_comparator_on && (sag >= (detect_trip_select ? 2'h1 : 2'h2));
    assign supply_warning = sag >= (warning_trip_select ? 2'h1 : 2'h2);
endmodule : supply_model
`default_nettype wire

// ### tb/low_voltage_power_mode_control_bench.sv
// Purpose: self-checking bench of the power mode control block
// Assumes: one wait state wishbone slave, synced comparator inputs
// Notes: register table rows first, then hand-written event cases
`timescale 1ns/100ps
`default_nettype none
module low_voltage_power_mode_control_bench;
    typedef struct packed {logic [3:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    // acknowledge, reserved and unmapped places must read zero
    row_t rows [6] = '{'{4'h0, 32'h01, 32'h01}, '{4'h0, 32'h3c, 32'h3c},
        '{4'h0, 32'h40, 32'h00}, '{4'h4, 32'h30, 32'h30},
        '{4'hc, 32'h07, 32'h07}, '{4'h2, 32'hff, 32'h00}};
    logic mclk, srst, por, cyc, stb, we, stop_a, stop_r, ack;
    logic sd, sw, con, dts, wts, rbe, sds, dirq, drr, irq;
    logic [3:0] adr, sel;
    logic [31:0] dat, dat_o, rd;
    logic [1:0] sag;
    int n_fail, comparisons;
    low_voltage_power_mode_control u_low_voltage_power_mode_control (.mclk(mclk),
        .srst(srst), .power_on_reset(por), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .supply_detect(sd), .supply_warning(sw), .stop_active(stop_a),
        .stop_recovered(stop_r), .detect_comparator_on(con), .detect_trip_select(dts),
        .warning_trip_select(wts), .reference_buffer_enable(rbe),
        .stop_depth_select(sds), .detect_irq(dirq), .detect_reset_req(drr), .irq(irq));
    supply_model u_supply_model (.sag(sag), .detect_comparator_on(con),
        .detect_trip_select(dts), .warning_trip_select(wts),
        .supply_detect(sd), .supply_warning(sw));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic summarize();
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // no cycle count assumed: waits for ack, the watchdog ends a hang
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        dat <= d;
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask : wb
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rd_chk
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        summarize();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        srst = 1'b1;
        por = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        dat = 32'h0;
        sag = 2'h0;
        stop_a = 1'b0;
        stop_r = 1'b0;
        n_fail = 0;
        comparisons = 0;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        por <= 1'b0;
        rd_chk(4'h0, 32'h0);
        rd_chk(4'h4, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b1, rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].e);
        end
        chk(dts, 1'b1);
        chk(wts, 1'b1);
        wb(1'b1, 4'h0, 32'h35);
        sag <= 2'h2;
        repeat (6) @(posedge mclk);
        rd_chk(4'h0, 32'hb5);
        chk(rbe, 1'b1);
        chk(dirq, 1'b1);
        chk(drr, 1'b1);
        chk(irq, 1'b1);
        wb(1'b1, 4'h0, 32'h15);
        repeat (2) @(posedge mclk);
        chk(dirq, 1'b0);
        chk(drr, 1'b1);
        sag <= 2'h0;
        // the wait drains the synchroniser so the acknowledge is not lost to a set
        repeat (4) @(posedge mclk);
        wb(1'b1, 4'h0, 32'h54);
        rd_chk(4'h0, 32'h14);
        wb(1'b1, 4'h0, 32'h10);
        sag <= 2'h2;
        repeat (6) @(posedge mclk);
        rd_chk(4'h0, 32'h10);
        chk(drr, 1'b0);
        chk(con, 1'b0);
        stop_a <= 1'b1;
        wb(1'b1, 4'h0, 32'h04);
        repeat (2) @(posedge mclk);
        chk(con, 1'b0);
        wb(1'b1, 4'h0, 32'h0c);
        repeat (2) @(posedge mclk);
        chk(con, 1'b1);
        stop_a <= 1'b0;
        rd_chk(4'h4, 32'hb0);
        wb(1'b1, 4'h4, 32'h70);
        rd_chk(4'h4, 32'hb0);
        sag <= 2'h0;
        repeat (4) @(posedge mclk);
        wb(1'b1, 4'h4, 32'h70);
        rd_chk(4'h4, 32'h30);
        rd_chk(4'h8, 32'h03);
        wb(1'b1, 4'hc, 32'h0);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wb(1'b1, 4'hc, 32'h07);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        wb(1'b1, 4'h8, 32'h07);
        rd_chk(4'h8, 32'h0);
        chk(irq, 1'b0);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_chk(4'h4, 32'h30);
        rd_chk(4'h0, 32'h0);
        wb(1'b1, 4'h4, 32'h31);
        wb(1'b1, 4'h4, 32'h30);
        rd_chk(4'h4, 32'h31);
        chk(sds, 1'b1);
        stop_r <= 1'b1;
        @(posedge mclk);
        stop_r <= 1'b0;
        rd_chk(4'h4, 32'h39);
        wb(1'b1, 4'h4, 32'h34);
        rd_chk(4'h4, 32'h31);
        summarize();
    end
endmodule : low_voltage_power_mode_control_bench
`default_nettype wire
